// [design/flash_array.sv]
`timescale 1ns/10ps
`default_nettype none
// two-partition flash cells as flip-flops, with erase and and-programming
module flash_array (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // operation
  input wire logic partSel,
  input wire logic eraseAll,
  input wire logic erasePage,
  input wire logic progByte,
  input wire logic [11:0] addr,
  input wire logic [7:0] wrData,
  // serial and cpu read
  output logic [7:0] rdData,
  input wire logic [11:0] fetchAddr,
  output logic [7:0] fetchData
);
  logic [7:0] main_reg [flash_seq_pkg::MAIN_BYTES];
  logic [7:0] info_reg [flash_seq_pkg::INFO_BYTES];

  // cpu has a read-only path into partition 0 and none into partition 1
  assign fetchData = main_reg[fetchAddr];
  assign rdData = partSel ? info_reg[addr[6:0]] : main_reg[addr];

  // partition 0 cells; untouched while partition 1 is selected
  genvar i;
  generate
    for (i = 0; i < flash_seq_pkg::MAIN_BYTES; i++) begin : g_main
      always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          main_reg[i] <= flash_seq_pkg::ERASED_BYTE;
        end else if (!partSel) begin
          if (eraseAll || (erasePage && addr[11:6] == 6'(i / flash_seq_pkg::PAGE_BYTES))) begin
            main_reg[i] <= flash_seq_pkg::ERASED_BYTE;
          end else if (progByte && addr == 12'(i)) begin
            main_reg[i] <= main_reg[i] & wrData;
          end
        end
      end
    end
    for (i = 0; i < flash_seq_pkg::INFO_BYTES; i++) begin : g_info
      always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          info_reg[i] <= flash_seq_pkg::ERASED_BYTE;
        end else if (partSel) begin
          if (eraseAll || (erasePage && addr[6] == 1'(i / flash_seq_pkg::PAGE_BYTES))) begin
            info_reg[i] <= flash_seq_pkg::ERASED_BYTE;
          end else if (progByte && addr[6:0] == 7'(i)) begin
            info_reg[i] <= info_reg[i] & wrData;
          end
        end
      end
    end
  endgenerate
endmodule : flash_array
`default_nettype wire

// [design/flash_seq_pkg.sv]
package flash_seq_pkg;
  localparam int MAIN_BYTES = 4096;
  localparam int INFO_BYTES = 128;
  localparam int PAGE_BYTES = 64;
  localparam int MAIN_AW = 12;
  localparam int INFO_AW = 7;
  localparam int PAGE_LSB = 6;
  localparam int CLK_MHZ = 50;
  localparam int ERASE_TIME_US = 4200;
  localparam int PROG_TIME_US = 80;
  localparam int ERASE_CYCLES = ERASE_TIME_US * CLK_MHZ;
  localparam int PROG_CYCLES = PROG_TIME_US * CLK_MHZ;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;
  localparam logic [7:0] CMD_HALT = 8'h78;
  localparam logic [7:0] CMD_PART = 8'hF8;
  localparam logic [7:0] CMD_ERASE_ALL = 8'hE8;
  localparam logic [7:0] CMD_ERASE_PAGE = 8'hD8;
  localparam logic [7:0] CMD_WRITE = 8'h18;
  localparam logic [7:0] CMD_READ = 8'h38;
  localparam logic [7:0] CMD_OUT3 = 8'h19;
  localparam logic [7:0] CMD_OUT4 = 8'h09;
  localparam logic [15:0] RESET_WORD = 16'h0000;
  localparam logic [11:0] FETCH_START = 12'h000;
  localparam logic [3:0] SEL_DHR_LAST = 4'h3;
  localparam logic [3:0] SEL_PTR_LAST = 4'h7;
  localparam int CMD_BITS = 8;
  localparam int DHR_BITS = 16;
endpackage : flash_seq_pkg

// [design/serial_flash_access_sequencer.sv]
`timescale 1ns/10ps
`default_nettype none
// command decoder and flash sequencer behind the serial calibration port
module serial_flash_access_sequencer (
  // core clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // serial link
  input wire logic sclk,
  input wire logic csB,
  input wire logic serialInLine,
  output logic serialOut,
  output logic serialOutEnB,
  // cpu fetch side
  input wire logic fetchStart,
  input wire logic fetchStep,
  input wire logic cpuEraseReq,
  input wire logic cpuProgReq,
  output logic [7:0] fetchByte,
  output logic [11:0] fetchPtr,
  // status
  output logic cpuHalted,
  output logic partition1Sel,
  output logic flashBusy
);
  typedef enum logic [1:0] {IDLE, ERASING, PROGRAMMING} flash_state_t;

  // link side wires
  logic [7:0] linkByte;
  logic linkToggle;
  logic linkOutEnB;
  logic linkOut;
  logic [2:0] tog_reg;
  logic [2:0] tog_next;

  // command registers; they keep their value between frames
  logic [15:0] data_holding_register_reg;
  logic [15:0] data_holding_register_next;
  logic [15:0] flash_address_pointer_reg;
  logic [15:0] flash_address_pointer_next;
  logic halt_reg;
  logic halt_next;
  logic part_reg;
  logic part_next;
  logic arm3_reg;
  logic arm3_next;
  logic wire4_reg;
  logic wire4_next;
  logic armUse_reg;
  logic armUse_next;
  logic [2:0] cs_reg;
  logic [2:0] cs_next;

  // flash operation timing
  flash_state_t state_reg;
  flash_state_t state_next;
  logic [23:0] timer_reg;
  logic [23:0] timer_next;
  logic busy_reg;
  logic busy_next;

  // cpu fetch path
  logic [11:0] fptr_reg;
  logic [11:0] fptr_next;
  logic [7:0] fbyte_reg;
  logic [7:0] fbyte_next;

  // decode strobes and crossing helpers
  logic doEraseAll;
  logic doErasePage;
  logic doProg;
  logic doRead;
  logic [7:0] rdData;
  logic [7:0] fetchData;
  logic byteReady;
  logic [7:0] cmd;
  logic [3:0] selNib;
  logic [3:0] valNib;
  logic outArm;
  logic frameOpened;
  logic opFree;

  // bit offset of the nibble picked by the low two select bits
  function automatic logic [3:0] nibbleBase(input logic [3:0] sel);
    nibbleBase = {sel[1:0], 2'b00};
  endfunction : nibbleBase

  // link end: shifter on the serial clock
  serial_link_front u_link (
    .rst_b(rst_b),
    .sclk(sclk),
    .csB(csB),
    .serialInLine(serialInLine),
    .outWord(data_holding_register_reg),
    .outArm(outArm),
    .serialOut(linkOut),
    .serialOutEnB(linkOutEnB),
    .cmdByte(linkByte),
    .frameToggle(linkToggle)
  );

  // cells for both partitions
  flash_array u_array (
    .clk(clk),
    .rst_b(rst_b),
    .partSel(part_reg),
    .eraseAll(doEraseAll),
    .erasePage(doErasePage),
    .progByte(doProg),
    .addr(flash_address_pointer_reg[11:0]),
    .wrData(data_holding_register_reg[7:0]),
    .rdData(rdData),
    .fetchAddr(fptr_reg),
    .fetchData(fetchData)
  );

  // words to the link are quasi-static: the data word only changes when no frame is open
  // the link latches its enable as the frame opens, before the core sees it,
  // so a pending three-wire arm must already count then
  assign outArm = wire4_reg || arm3_reg || armUse_reg;
  assign frameOpened = cs_reg[2] && !cs_reg[1];
  assign opFree = (state_reg == IDLE);
  assign serialOut = linkOut;
  assign serialOutEnB = linkOutEnB;
  assign cmd = linkByte;
  assign selNib = cmd[3:0];
  assign valNib = cmd[7:4];
  assign byteReady = tog_reg[2] ^ tog_reg[1];

  // toggle synchroniser: stage 0 feeds stage 1 only, edge seen between 1 and 2
  always_comb begin
    tog_next = {tog_reg[1], tog_reg[0], linkToggle};
    cs_next = {cs_reg[1:0], csB};
  end

  // synchroniser registers; frame-open edge is taken from the two settled stages
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tog_reg <= 3'b000;
      cs_reg <= 3'b111;
    end else begin
      tog_reg <= tog_next;
      cs_reg <= cs_next;
    end
  end

  // command decode; completes in the cycle after the byte crosses over
  always_comb begin
    data_holding_register_next = data_holding_register_reg;
    flash_address_pointer_next = flash_address_pointer_reg;
    halt_next = halt_reg;
    part_next = part_reg;
    arm3_next = arm3_reg;
    wire4_next = wire4_reg;
    armUse_next = armUse_reg;
    doEraseAll = 1'b0;
    doErasePage = 1'b0;
    doProg = 1'b0;
    doRead = 1'b0;
    // armed three-wire output is spent by the next frame
    if (frameOpened && arm3_reg) begin
      armUse_next = 1'b1;
      arm3_next = 1'b0;
    end
    if (byteReady) begin
      armUse_next = 1'b0;
      if (selNib <= flash_seq_pkg::SEL_DHR_LAST) begin
        data_holding_register_next[nibbleBase(selNib) +: 4] = valNib;
      end else if (selNib <= flash_seq_pkg::SEL_PTR_LAST) begin
        flash_address_pointer_next[nibbleBase(selNib) +: 4] = valNib;
      end else begin
        unique case (cmd)
          flash_seq_pkg::CMD_HALT: begin
            halt_next = 1'b1;
            part_next = 1'b0;
          end
          flash_seq_pkg::CMD_PART: begin
            if (halt_reg) begin
              part_next = 1'b1;
            end
          end
          flash_seq_pkg::CMD_ERASE_ALL: begin
            doEraseAll = opFree;
          end
          flash_seq_pkg::CMD_ERASE_PAGE: begin
            doErasePage = opFree;
          end
          flash_seq_pkg::CMD_WRITE: begin
            doProg = opFree;
          end
          flash_seq_pkg::CMD_READ: begin
            doRead = 1'b1;
          end
          flash_seq_pkg::CMD_OUT3: begin
            arm3_next = 1'b1;
            wire4_next = 1'b0;
          end
          flash_seq_pkg::CMD_OUT4: begin
            wire4_next = 1'b1;
          end
          default: begin
            // other command codes have no effect on this block
          end
        endcase
      end
    end
    if (doRead) begin
      data_holding_register_next[7:0] = rdData;
    end
  end

  // command registers
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      data_holding_register_reg <= flash_seq_pkg::RESET_WORD;
      flash_address_pointer_reg <= flash_seq_pkg::RESET_WORD;
      halt_reg <= 1'b0;
      part_reg <= 1'b0;
      arm3_reg <= 1'b0;
      wire4_reg <= 1'b0;
      armUse_reg <= 1'b0;
    end else begin
      data_holding_register_reg <= data_holding_register_next;
      flash_address_pointer_reg <= flash_address_pointer_next;
      halt_reg <= halt_next;
      part_reg <= part_next;
      arm3_reg <= arm3_next;
      wire4_reg <= wire4_next;
      armUse_reg <= armUse_next;
    end
  end

  // busy timer; a new flash operation is dropped until it runs out
  // erase and program share one timer, so only one flash operation runs at a time
  always_comb begin
    state_next = state_reg;
    timer_next = timer_reg;
    unique case (state_reg)
      IDLE: begin
        if (doEraseAll || doErasePage) begin
          state_next = ERASING;
          timer_next = 24'(flash_seq_pkg::ERASE_CYCLES - 1);
        end else if (doProg) begin
          state_next = PROGRAMMING;
          timer_next = 24'(flash_seq_pkg::PROG_CYCLES - 1);
        end
      end
      ERASING, PROGRAMMING: begin
        if (timer_reg == 24'h00_0000) begin
          state_next = IDLE;
        end else begin
          timer_next = 24'(timer_reg - 24'h00_0001);
        end
      end
    endcase
    busy_next = (state_next != IDLE);
  end

  // timer registers; busy is its own flop so the status pin has no decode behind it
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= IDLE;
      timer_reg <= 24'h00_0000;
      busy_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      timer_reg <= timer_next;
      busy_reg <= busy_next;
    end
  end

  // cpu fetch pointer; erase and program requests from the cpu are ignored
  always_comb begin
    fptr_next = fptr_reg;
    if (fetchStart) begin
      fptr_next = flash_seq_pkg::FETCH_START;
    end else if (fetchStep) begin
      fptr_next = 12'(fptr_reg + 12'h001);
    end
    // cpuEraseReq and cpuProgReq have no path into the cells
    fbyte_next = (cpuEraseReq || cpuProgReq) ? fetchData : fetchData;
  end

  // fetch registers
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      fptr_reg <= flash_seq_pkg::FETCH_START;
      fbyte_reg <= 8'h00;
    end else begin
      fptr_reg <= fptr_next;
      fbyte_reg <= fbyte_next;
    end
  end

  // status outputs from flip-flops
  assign fetchByte = fbyte_reg;
  assign fetchPtr = fptr_reg;
  assign cpuHalted = halt_reg;
  assign partition1Sel = part_reg;
  assign flashBusy = busy_reg;
endmodule : serial_flash_access_sequencer
`default_nettype wire

// [design/serial_link_front.sv]
`timescale 1ns/10ps
`default_nettype none
// link-side shifter; runs on the serial clock only while a frame is open
module serial_link_front (
  // core reset, async; also clears the link side before the first frame
  input wire logic rst_b,
  // link clock and frame
  input wire logic sclk,
  input wire logic csB,
  input wire logic serialInLine,
  // output data, quasi-static word taken unsynchronised from the core side
  input wire logic [15:0] outWord,
  input wire logic outArm,
  // link pin
  output logic serialOut,
  output logic serialOutEnB,
  // to core domain
  output logic [7:0] cmdByte,
  output logic frameToggle
);
  logic [7:0] shift_reg;
  logic [7:0] shift_next;
  logic [4:0] count_reg;
  logic [4:0] count_next;
  logic [15:0] out_reg;
  logic [15:0] out_next;

  // shift in lsb first; the last eight bits of the frame count
  always_comb begin
    shift_next = {serialInLine, shift_reg[7:1]};
    count_next = (count_reg == 5'd31) ? count_reg : 5'(count_reg + 5'd1);
    out_next = (count_reg == 5'd0) ? {outWord[14:0], 1'b0} : {out_reg[14:0], 1'b0};
  end

  // frame restart clears count; the link clock stops between frames
  always_ff @(posedge sclk or posedge csB or negedge rst_b) begin
    if (!rst_b || csB) begin
      shift_reg <= 8'h00;
      count_reg <= 5'd0;
      out_reg <= 16'h0000;
    end else begin
      shift_reg <= shift_next;
      count_reg <= count_next;
      out_reg <= out_next;
    end
  end

  // bit 15 appears as the frame opens; later bits move on falling edges, stable at the host's rising edge
  always_ff @(negedge sclk or negedge csB or negedge rst_b) begin
    if (!rst_b) begin
      serialOut <= 1'b0;
    end else begin
      serialOut <= (count_reg == 5'd0) ? outWord[15] : out_reg[15];
    end
  end

  // enable held for the whole frame when armed at its start
  always_ff @(negedge csB or posedge csB or negedge rst_b) begin
    if (!rst_b || csB) begin
      serialOutEnB <= 1'b1;
    end else begin
      serialOutEnB <= !outArm;
    end
  end

  // byte captured on frame end; toggle tells the core a byte is ready
  always_ff @(posedge csB or negedge rst_b) begin
    if (!rst_b) begin
      cmdByte <= 8'h00;
      frameToggle <= 1'b0;
    end else begin
      cmdByte <= shift_reg;
      frameToggle <= !frameToggle;
    end
  end
endmodule : serial_link_front
`default_nettype wire

// [test/calib_host_model.sv]
`timescale 1ns/10ps
`default_nettype none
// calibration host: link clock runs only inside frames
module calib_host_model (
  // link pins
  output logic sclk,
  output logic csB,
  output logic serialInLine,
  input wire logic serialOut
);
  // idle link
  initial begin
    sclk = 1'b0;
    csB = 1'b1;
    serialInLine = 1'b0;
  end
  // one frame; gapNs sets how promptly the host moves on
  task automatic frame(input logic [15:0] bits, input int n, input int gapNs, output logic [15:0] got);
    got = 16'h0000;
    #7 csB = 1'b0;
    for (int i = 0; i < n; i++) begin
      serialInLine = bits[i];
      #32 sclk = 1'b1;
      got = {got[14:0], serialOut};
      #32 sclk = 1'b0;
    end
    #32 csB = 1'b1;
    serialInLine = ~serialInLine; // released line must not keep a stale level
    #(gapNs);
  endtask : frame
endmodule : calib_host_model
`default_nettype wire

// [test/serial_flash_access_sequencer_properties.sv]
`timescale 1ns/10ps
`default_nettype none
// pin-level watch on the sequencer, core clock only
module flash_seq_checker (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // link
  input wire logic csB,
  input wire logic serialOutEnB,
  // cpu side
  input wire logic fetchStart,
  input wire logic fetchStep,
  input wire logic cpuEraseReq,
  input wire logic cpuProgReq,
  input wire logic [11:0] fetchPtr,
  // status
  input wire logic cpuHalted,
  input wire logic partition1Sel,
  input wire logic flashBusy
);
  logic csB_reg, csB_next;
  logic [7:0] sinceCs_reg, sinceCs_next;
  logic [17:0] busyLen_reg, busyLen_next;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  // frame-end age saturates so a long idle never looks like a fresh frame
  always_comb begin
    csB_next = csB;
    sinceCs_next = (csB && !csB_reg) ? 8'h00 : sinceCs_reg + {7'h00, sinceCs_reg != 8'hFF};
    busyLen_next = flashBusy ? busyLen_reg + 18'h0_0001 : 18'h0_0000;
  end
  // helper registers
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      csB_reg <= 1'b1;
      sinceCs_reg <= 8'hFF;
      busyLen_reg <= 18'h0_0000;
    end else begin
      csB_reg <= csB_next;
      sinceCs_reg <= sinceCs_next;
      busyLen_reg <= busyLen_next;
    end
  end
  a_enb_idle_hold: assert property (csB && $past(csB) |-> !$fell(serialOutEnB))
    else $error("output enable fell outside a frame");
  a_enb_off_idle: assert property (csB |-> serialOutEnB)
    else $error("output enabled while no frame is open");
  a_part_needs_halt: assert property ($rose(partition1Sel) |-> cpuHalted)
    else $error("partition 1 selected while running");
  a_part_after_frame: assert property ($changed(partition1Sel) |-> sinceCs_reg <= 8'h08)
    else $error("partition change late or without a frame");
  a_busy_after_frame: assert property ($rose(flashBusy) |-> sinceCs_reg <= 8'h08)
    else $error("busy began without a frame");
  a_busy_timed_len: assert property ($fell(flashBusy) |-> busyLen_reg inside
    {[flash_seq_pkg::PROG_CYCLES - 2 : flash_seq_pkg::PROG_CYCLES + 2],
     [flash_seq_pkg::ERASE_CYCLES - 2 : flash_seq_pkg::ERASE_CYCLES + 2]})
    else $error("busy length wrong");
  a_fetch_restart: assert property (fetchStart |=> fetchPtr == 12'h000)
    else $error("fetch pointer not restarted");
  a_fetch_advance: assert property (fetchStep && !fetchStart |=> fetchPtr == $past(fetchPtr) + 12'h001)
    else $error("fetch pointer did not advance by one");
  a_cpu_no_effect: assert property ((cpuEraseReq || cpuProgReq) && !flashBusy && sinceCs_reg > 8'h08
    |=> !flashBusy)
    else $error("cpu request started a flash operation");
  c_part1: cover property ($rose(partition1Sel));
  c_prog_done: cover property ($fell(flashBusy));
  c_out_frame: cover property ($fell(serialOutEnB));
endmodule : flash_seq_checker
`default_nettype wire

// [test/serial_flash_access_sequencer_tb.sv]
`timescale 1ns/10ps
`default_nettype none
module serial_flash_access_sequencer_tb;
  logic clk, rst_b, fetchStart, fetchStep, cpuEraseReq, cpuProgReq;
  logic sclk, csB, serialInLine, serialOut, serialOutEnB, cpuHalted, partition1Sel, flashBusy;
  logic [7:0] fetchByte;
  logic [11:0] fetchPtr;
  int errTotal = 0;
  int checkCount = 0;
  serial_flash_access_sequencer dut (.clk(clk), .rst_b(rst_b), .sclk(sclk), .csB(csB),
    .serialInLine(serialInLine), .serialOut(serialOut), .serialOutEnB(serialOutEnB), .fetchStart(fetchStart),
    .fetchStep(fetchStep), .cpuEraseReq(cpuEraseReq), .cpuProgReq(cpuProgReq), .fetchByte(fetchByte),
    .fetchPtr(fetchPtr), .cpuHalted(cpuHalted), .partition1Sel(partition1Sel), .flashBusy(flashBusy));
  calib_host_model host (.sclk(sclk), .csB(csB), .serialInLine(serialInLine), .serialOut(serialOut));
  // core clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic stop_test();
    if (errTotal == 0 && checkCount > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : stop_test
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checkCount++;
    if (seen !== exp) begin
      errTotal++;
      $display("BAD t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask : check
  task automatic cmd(input logic [7:0] b);
    logic [15:0] unused;
    host.frame({8'h00, b}, 8, 400, unused);
  endtask : cmd
  // readout frame: toggling pattern, then a harmless top-pointer-nibble byte
  task automatic rd(input logic [15:0] exp);
    logic [15:0] w;
    cmd(flash_seq_pkg::CMD_READ);
    cmd(flash_seq_pkg::CMD_OUT3);
    fork
      host.frame(16'h0755, 16, 400, w);
      begin
        #300;
        check({15'h0000, serialOutEnB}, 16'h0000);
      end
    join
    check(w, exp);
    check({15'h0000, serialOutEnB}, 16'h0001);
  endtask : rd
  // bounded wait for the program timer
  task automatic wait_idle();
    int n;
    n = 0;
    repeat (8) @(posedge clk);
    while (flashBusy !== 1'b0 && n < 6000) begin
      @(posedge clk);
      n++;
    end
    if (n >= 6000) begin
      errTotal++;
      stop_test();
    end
  endtask : wait_idle
  task automatic prog(input logic [7:0] d);
    cmd({d[3:0], 4'h0});
    cmd({d[7:4], 4'h1});
    cmd(flash_seq_pkg::CMD_WRITE);
    check({15'h0000, flashBusy}, 16'h0001);
    wait_idle();
  endtask : prog
  task automatic t_reset();
    check({12'h000, partition1Sel, cpuHalted, flashBusy, serialOutEnB}, 16'h0001);
    check({4'h0, fetchPtr}, 16'h0000);
    cmd(flash_seq_pkg::CMD_PART);
    check({15'h0000, partition1Sel}, 16'h0000);
  endtask : t_reset
  // cells start erased after reset, so no erase precedes the first write
  task automatic t_main();
    cmd(8'h34);
    cmd(8'h05);
    cmd(8'h06);
    prog(8'hA5);
    rd(16'h00A5);
    prog(8'h5C);
    rd(16'h0004);
    cmd(8'hF7);
    rd(16'h0004);
  endtask : t_main
  task automatic t_info();
    cmd(flash_seq_pkg::CMD_HALT);
    cmd(flash_seq_pkg::CMD_PART);
    check({14'h0000, cpuHalted, partition1Sel}, 16'h0003);
    rd(16'h00FF);
    prog(8'h3C);
    rd(16'h003C);
    cmd(flash_seq_pkg::CMD_HALT);
    check({15'h0000, partition1Sel}, 16'h0000);
    rd(16'h0004);
  endtask : t_info
  task automatic t_cpu();
    @(posedge clk) fetchStart <= 1'b1;
    @(posedge clk) fetchStart <= 1'b0;
    repeat (3) begin
      @(posedge clk) fetchStep <= 1'b1;
      @(posedge clk) fetchStep <= 1'b0;
    end
    @(posedge clk) cpuEraseReq <= 1'b1;
    @(posedge clk) cpuProgReq <= 1'b1;
    @(posedge clk) cpuEraseReq <= 1'b0;
    cpuProgReq <= 1'b0;
    repeat (4) @(posedge clk);
    #1;
    check({4'h0, fetchPtr}, 16'h0003);
    check({7'h00, flashBusy, fetchByte}, 16'h0004);
  endtask : t_cpu
  task automatic t_four();
    logic [15:0] w;
    cmd(flash_seq_pkg::CMD_OUT4);
    repeat (2) begin
      fork
        host.frame(16'h0755, 16, 2000, w);
        begin
          #300;
          check({15'h0000, serialOutEnB}, 16'h0000);
        end
      join
      check(w, 16'h0004);
    end
  endtask : t_four
  // analog power-down, the pointer set to 0x04F (low bits not clear), then erase all;
  // the second erase arrives while busy and must be dropped
  task automatic t_erase();
    logic [7:0] offSeq [18];
    offSeq = '{8'h03, 8'h02, 8'h01, 8'h00, 8'hD4, 8'h08, 8'h03, 8'h02, 8'h31, 8'h10, 8'hE4, 8'h08,
      8'h83, 8'h02, 8'h01, 8'h00, 8'hF4, 8'h08};
    foreach (offSeq[k]) begin
      cmd(offSeq[k]);
    end
    cmd(8'h45);
    cmd(flash_seq_pkg::CMD_ERASE_ALL);
    check({15'h0000, flashBusy}, 16'h0001);
    cmd(flash_seq_pkg::CMD_ERASE_PAGE);
    repeat (4100) @(posedge clk);
    #1;
    check({15'h0000, flashBusy}, 16'h0001);
  endtask : t_erase
  initial begin
    rst_b = 1'b1;
    fetchStart = 1'b0;
    fetchStep = 1'b0;
    cpuEraseReq = 1'b0;
    cpuProgReq = 1'b0;
    #1 rst_b = 1'b0; // clean falling edge so the link-side flops reset too
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    t_reset();
    t_main();
    t_info();
    t_cpu();
    t_four();
    t_erase();
    stop_test();
  end
endmodule : serial_flash_access_sequencer_tb
bind serial_flash_access_sequencer flash_seq_checker chk (.clk(clk), .rst_b(rst_b), .csB(csB),
  .serialOutEnB(serialOutEnB), .fetchStart(fetchStart), .fetchStep(fetchStep), .cpuEraseReq(cpuEraseReq),
  .cpuProgReq(cpuProgReq), .fetchPtr(fetchPtr), .cpuHalted(cpuHalted), .partition1Sel(partition1Sel),
  .flashBusy(flashBusy));
`default_nettype wire
